/* File: cih_regs.vh */
`ifndef CIH_REGS_VH
`define CIH_REGS_VH
// APB register byte offsets.
`define CIH_OFS_PEND 12'h000
`define CIH_OFS_EN 12'h004
`define CIH_OFS_PRIO 12'h008
`define CIH_OFS_HWCLR 12'h00c
`define CIH_OFS_STAT 12'h010
`define CIH_OFS_IRQST 12'h014
`define CIH_OFS_IRQMSK 12'h018
`define CIH_OFS_VBASE 12'h01c
// Field positions and widths.
`define CIH_NSRC 8
`define CIH_GIE_BIT 7
// Reset values.
`define CIH_EN_RST 8'h00
`define CIH_PRIO_RST 8'h00
`define CIH_HWCLR_RST 8'h00
`define CIH_VBASE_RST 16'h0003
// Vector spacing in bytes between consecutive sources.
`define CIH_VSTEP 16'h0008
// Status event bit positions.
`define CIH_EV_TAKE 0
`define CIH_EV_PREEMPT 1
`define CIH_EV_RETI 2
`endif

/* File: cih_cpu_interrupt_handler.v */
// Overview of operation
// R01 - Eight request sources, each assigned one of two priority levels.
// R02 - A source event sets its pending flag regardless of its enable.
// R03 - Enabled pending request vectors after the current instruction ends.
// R04 - Return from interrupt resumes at the saved next instruction address.
// R05 - Pending flags of disabled sources raise no request.
// R06 - Global enable at bit 7 gates every individual source enable.
// R07 - Each source has its own independent enable bit; source 7 has none here and is always enabled.
// R08 - Enable cleared then single-cycle instruction may still take request.
// R09 - Software follows a global disable with a multi-byte instruction.
// R10 - Selected flags clear on vectoring; others software clears.
// R11 - Flag still set after return re-enters after one more instruction; here two more instructions run before re-entry.
// R12 - Software writing one to a pending flag acts as a real event.
// R13 - USB function controller flag lives in its own space, not here.
// R14 - All timing counted in system clocks, no machine cycles.
// R15 - Most instructions take as many clocks as program bytes.
// R16 - Untaken conditional branch completes one clock sooner.
// R17 - Opcodes and flag effects are the core's concern; only timing here.
// R18 - High priority preempts low; equal or lower waits for return.
`timescale 1ns/1ps
`include "cih_regs.vh"

module cih_cpu_interrupt_handler (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Peripheral events, one-cycle pulses from same-clock logic.
    input wire [7:0] src_event,
    // USB function controller request level, its flag kept in its own space.
    input wire usb_function_ctrl_req,
    // Core pipeline handshake.
    input wire instr_done,
    input wire [3:0] instr_bytes,
    input wire instr_branch,
    input wire instr_taken,
    input wire instr_clr_gie,
    input wire instr_reti,
    input wire [15:0] next_pc,
    // Vectoring outputs to the core.
    output reg vec_call,
    output reg [15:0] vec_addr,
    output reg [15:0] ret_addr,
    output reg [3:0] instr_cycles,
    output reg global_irq_enable,
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Lowest-index set bit wins within a priority group.
    function [3:0] pick;
        input [7:0] v;
        integer i;
        begin
            pick = 4'h8;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    pick = i[3:0];
                end
            end
        end
    endfunction

    // Fixed vector: base plus index times spacing.
    function [15:0] vec_of;
        input [15:0] base;
        input [2:0] idx;
        begin
            vec_of = base + (`CIH_VSTEP * {13'h0000, idx});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    reg [7:0] pend_ff;
    reg [6:0] en_ff;
    reg [7:0] prio_ff;
    reg [7:0] hwclr_ff;
    reg [15:0] vbase_ff;
    reg [2:0] irqst_ff;
    reg [2:0] irqmsk_ff;
    reg [1:0] act_ff;          // Bit 0 low-level active, bit 1 high-level active.
    reg [1:0] act_stack_ff;    // Level of the preempted routine when nested.
    reg [15:0] saved_pc_ff;
    reg [15:0] saved_pc2_ff;
    reg reti_hold_ff;          // Blocks vectoring for one instruction after return.

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire addr_ok = (paddr == `CIH_OFS_PEND) | (paddr == `CIH_OFS_EN) |
        (paddr == `CIH_OFS_PRIO) | (paddr == `CIH_OFS_HWCLR) | (paddr == `CIH_OFS_STAT) |
        (paddr == `CIH_OFS_IRQST) | (paddr == `CIH_OFS_IRQMSK) | (paddr == `CIH_OFS_VBASE);

    ////////////////////////////////////////////////////////////////////////
    // Arbitration.

    // Source 7 uses the USB level, not a local flag.
    wire [7:0] flags = {usb_function_ctrl_req, pend_ff[6:0]}; // [R13]
    // Gate sources 0-6 by individual enables, then all by the global enable.
    wire [7:0] en_all = {1'b1, en_ff};                            // [R07]
    wire [7:0] req = flags & en_all & {8{global_irq_enable}};    // [R05] [R06]
    wire [7:0] req_hi = req & prio_ff;                            // [R01]
    wire [7:0] req_lo = req & ~prio_ff;
    wire [3:0] win_hi = pick(req_hi);
    wire [3:0] win_lo = pick(req_lo);
    // High preempts low; nothing preempts high; low waits for any active.
    wire hi_ok = (req_hi != 8'h00) & ~act_ff[1];                 // [R18]
    wire lo_ok = (req_lo != 8'h00) & (act_ff == 2'b00);          // [R18]
    wire [3:0] win = hi_ok ? win_hi : win_lo;
    // Take at instruction boundary; an enable-clearing instruction of one
    // cycle has not yet updated the enable, so the request can still go.
    wire take = instr_done & ~instr_reti & ~reti_hold_ff & (hi_ok | lo_ok) &
        ~(instr_clr_gie & (instr_bytes > 4'h1));                  // [R03] [R08]

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle count reported to the core's sequencer.

    // Cycles equal program bytes; taken branch adds one clock.
    // Opcode decoding stays with the core, so only timing is reported here. [R17]
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_cycles <= 4'h1;
        end else if (instr_done) begin
            instr_cycles <= (instr_branch & instr_taken) ? instr_bytes + 4'h1
                : instr_bytes;                                    // [R14] [R15] [R16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags: set beats both clears.

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= 8'h00;
        end else begin
            pend_ff <= (pend_ff
                & ~((wr_en & (paddr == `CIH_OFS_PEND) & ~(&pwdata[7:0])) ? 8'hff : 8'h00)
                & ~((take & hwclr_ff[win[2:0]]) ? (8'h01 << win[2:0]) : 8'h00)) // [R10]
                | src_event                                        // [R02]
                | ((wr_en & (paddr == `CIH_OFS_PEND)) ? pwdata[7:0] : 8'h00); // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers, global enable and core handshake.

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_ff <= 7'h00;
            global_irq_enable <= 1'b0;
            prio_ff <= `CIH_PRIO_RST;
            hwclr_ff <= `CIH_HWCLR_RST;
            vbase_ff <= `CIH_VBASE_RST;
            irqmsk_ff <= 3'h0;
            act_ff <= 2'b00;
            act_stack_ff <= 2'b00;
            saved_pc_ff <= 16'h0000;
            saved_pc2_ff <= 16'h0000;
            reti_hold_ff <= 1'b0;
            vec_call <= 1'b0;
            vec_addr <= 16'h0000;
            ret_addr <= 16'h0000;
        end else begin
            vec_call <= take;
            if (wr_en & (paddr == `CIH_OFS_EN)) begin
                en_ff <= pwdata[6:0];
                global_irq_enable <= pwdata[`CIH_GIE_BIT];        // [R06]
            end else if (instr_done & instr_clr_gie) begin
                global_irq_enable <= 1'b0;                        // [R08]
            end
            if (wr_en & (paddr == `CIH_OFS_PRIO)) begin
                prio_ff <= pwdata[7:0];
            end
            if (wr_en & (paddr == `CIH_OFS_HWCLR)) begin
                hwclr_ff <= pwdata[7:0];
            end
            if (wr_en & (paddr == `CIH_OFS_VBASE)) begin
                vbase_ff <= pwdata[15:0];
            end
            if (wr_en & (paddr == `CIH_OFS_IRQMSK)) begin
                irqmsk_ff <= pwdata[2:0];
            end
            // Two instructions must complete after a return before re-entry.
            if (instr_done) begin
                reti_hold_ff <= instr_reti;                       // [R11]
            end
            if (take) begin
                vec_addr <= vec_of(vbase_ff, win[2:0]);           // [R03]
                ret_addr <= next_pc;
                saved_pc_ff <= next_pc;
                saved_pc2_ff <= saved_pc_ff;
                act_stack_ff <= act_ff;
                act_ff <= hi_ok ? (act_ff | 2'b10) : 2'b01;       // [R18]
            end else if (instr_done & instr_reti & (act_ff != 2'b00)) begin
                // Resume at the instruction after the interrupted one.
                ret_addr <= saved_pc_ff;                          // [R04]
                saved_pc_ff <= saved_pc2_ff;
                act_ff <= act_stack_ff;
                act_stack_ff <= 2'b00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event status and masked interrupt line; set wins over clear.

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqst_ff <= 3'h0;
            irq <= 1'b0;
        end else begin
            irqst_ff <= (irqst_ff & ~((wr_en & (paddr == `CIH_OFS_IRQST)) ? pwdata[2:0] : 3'h0))
                | {instr_done & instr_reti & (act_ff != 2'b00),
                   take & hi_ok & act_ff[0], take};
            irq <= |(irqst_ff & irqmsk_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB: zero wait states, error on unmapped address.

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `CIH_OFS_PEND: prdata <= {24'h000000, flags};
                    `CIH_OFS_EN: prdata <= {24'h000000, global_irq_enable, en_ff};
                    `CIH_OFS_PRIO: prdata <= {24'h000000, prio_ff};
                    `CIH_OFS_HWCLR: prdata <= {24'h000000, hwclr_ff};
                    `CIH_OFS_STAT: prdata <= {17'h00000, act_ff, saved_pc_ff[7:0],
                        reti_hold_ff, win[2:0], hi_ok | lo_ok};
                    `CIH_OFS_IRQST: prdata <= {29'h00000000, irqst_ff};
                    `CIH_OFS_IRQMSK: prdata <= {29'h00000000, irqmsk_ff};
                    `CIH_OFS_VBASE: prdata <= {16'h0000, vbase_ff};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // cih_cpu_interrupt_handler

/* File: cih_checker.sv */
`timescale 1ns/1ps
module cih_checker (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Watched ports.
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire instr_done,
    input wire [3:0] instr_bytes,
    input wire instr_branch,
    input wire instr_taken,
    input wire instr_reti,
    input wire [15:0] next_pc,
    input wire vec_call,
    input wire [15:0] ret_addr,
    input wire [3:0] instr_cycles
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // A setup cycle, and a completed instruction that launched a call.
    sequence setup_s; psel && !penable; endsequence
    sequence take_s; instr_done ##1 vec_call; endsequence
    // The slave never stretches an access, so one cycle after setup must answer.
    apb_answer_a: assert property (setup_s |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    vec_pulse_a: assert property (vec_call |=> !vec_call) else $error("call held");
    vec_cause_a: assert property (vec_call |-> $past(instr_done)) else $error("no cause");
    reti_block_a: assert property (vec_call |-> !$past(instr_reti)) else $error("reti");
    ret_save_a: assert property (take_s |-> ret_addr == $past(next_pc)) else $error("ret");
    byte_time_a: assert property (instr_done && !instr_branch
        |=> instr_cycles == $past(instr_bytes)) else $error("cycles");
    branch_time_a: assert property (instr_done && instr_branch
        |=> instr_cycles == $past(instr_bytes) + {3'h0, $past(instr_taken)}) else $error("br");
endmodule // cih_checker
////////////////////////////////////////////////////////////////////////////////
bind cih_cpu_interrupt_handler cih_checker u_chk (.ref_clk, .sys_rst, .psel, .penable,
    .pready, .pslverr, .instr_done, .instr_bytes, .instr_branch, .instr_taken,
    .instr_reti, .next_pc, .vec_call, .ret_addr, .instr_cycles);

/* File: cih_core_model.sv */
`timescale 1ns/1ps
module cih_core_model (
    // Clock.
    input wire ref_clk,
    // Pipeline completions and peripheral events.
    output logic instr_done,
    output logic [3:0] instr_bytes,
    output logic instr_branch,
    output logic instr_taken,
    output logic instr_clr_gie,
    output logic instr_reti,
    output logic [15:0] next_pc,
    output logic [7:0] src_event
);
    // Idle pipeline at time zero.
    initial begin
        instr_done = 1'b0;
        {instr_bytes, instr_branch, instr_taken, instr_clr_gie, instr_reti} = 8'h0;
        next_pc = 16'h0;
        src_event = 8'h0;
    end
    // Qualifiers are junk outside instr_done, so a design that ignores the strobe is caught.
    task automatic exec(input logic [3:0] nb, input logic [3:0] fl, input logic [15:0] pc);
        @(posedge ref_clk);
        instr_done <= 1'b1;
        {instr_bytes, instr_branch, instr_taken, instr_clr_gie, instr_reti} <= {nb, fl};
        next_pc <= pc;
        @(posedge ref_clk);
        instr_done <= 1'b0;
        {instr_bytes, instr_branch, instr_taken, instr_clr_gie, instr_reti} <= ~{nb, fl};
        next_pc <= ~pc;
    endtask
    // One-clock event pulse from a peripheral.
    task automatic fire(input logic [7:0] ev);
        @(posedge ref_clk);
        src_event <= ev;
        @(posedge ref_clk);
        src_event <= 8'h0;
    endtask
endmodule // cih_core_model

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "cih_regs.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic usb_function_ctrl_req = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, vec_call, global_irq_enable, irq;
    logic [15:0] vec_addr, ret_addr;
    logic [3:0] instr_cycles, instr_bytes;
    wire instr_done, instr_branch, instr_taken, instr_clr_gie, instr_reti;
    wire [15:0] next_pc;
    wire [7:0] src_event;
    int errors = 0;
    int checks = 0;
    cih_core_model u_core (.ref_clk, .instr_done, .instr_bytes, .instr_branch, .instr_taken,
        .instr_clr_gie, .instr_reti, .next_pc, .src_event);
    cih_cpu_interrupt_handler u_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .src_event, .usb_function_ctrl_req, .instr_done,
        .instr_bytes, .instr_branch, .instr_taken, .instr_clr_gie, .instr_reti, .next_pc,
        .vec_call, .vec_addr, .ret_addr, .instr_cycles, .global_irq_enable, .irq);
    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock, and a hard stop in case a wait is missed.
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        #500000;
        errors++;
        complete_run();
    end
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            complete_run();
        end
    endtask
    // One instruction; the call, if any, shows in the cycle after completion.
    task automatic step(input logic [3:0] nb, input logic [3:0] fl, input logic [15:0] pc,
        input logic ev);
        u_core.exec(nb, fl, pc);
        #1;
        `CHK("vec_call", ev, vec_call)
    endtask
    function automatic logic [15:0] vaddr(input int i);
        return `CIH_VBASE_RST + `CIH_VSTEP * i[15:0];
    endfunction
    // Flags are {branch, taken, clear global enable, return}.
    initial begin
        logic [11:0] ra[4];
        logic [31:0] rv[4];
        ra = '{`CIH_OFS_EN, `CIH_OFS_PRIO, `CIH_OFS_HWCLR, `CIH_OFS_VBASE};
        rv = '{{24'h0, `CIH_EN_RST}, {24'h0, `CIH_PRIO_RST}, {24'h0, `CIH_HWCLR_RST},
            {16'h0, `CIH_VBASE_RST}};
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK("reset", rv[i], rd)
        end
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped", 1'b1, err)
        step(4'h3, 4'h0, 16'h0010, 1'b0);
        `CHK("cycles", 4'h3, instr_cycles)
        step(4'h2, 4'hc, 16'h0020, 1'b0);
        `CHK("taken", 4'h3, instr_cycles)
        step(4'h2, 4'h8, 16'h0030, 1'b0);
        `CHK("untaken", 4'h2, instr_cycles)
        @(posedge ref_clk);
        usb_function_ctrl_req <= 1'b1;
        apb(1'b0, `CIH_OFS_PEND, 32'h0);
        `CHK("usb", 1'b1, rd[7])
        usb_function_ctrl_req <= 1'b0;
        u_core.fire(8'h04);
        apb(1'b0, `CIH_OFS_PEND, 32'h0);
        `CHK("pend", 1'b1, rd[2])
        step(4'h1, 4'h0, 16'h0040, 1'b0);
        apb(1'b1, `CIH_OFS_EN, 32'h04);
        step(4'h1, 4'h0, 16'h0050, 1'b0);
        apb(1'b1, `CIH_OFS_EN, 32'h84);
        apb(1'b1, `CIH_OFS_IRQMSK, 32'h1);
        step(4'h2, 4'h2, 16'h0060, 1'b0);
        `CHK("gie", 1'b0, global_irq_enable)
        apb(1'b1, `CIH_OFS_EN, 32'h84);
        step(4'h1, 4'h0, 16'h0100, 1'b1);
        `CHK("vector", vaddr(2), vec_addr)
        `CHK("return", 16'h0100, ret_addr)
        apb(1'b0, `CIH_OFS_IRQST, 32'h0);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, `CIH_OFS_IRQST, 32'h1);
        apb(1'b0, `CIH_OFS_IRQST, 32'h0);
        `CHK("irq clr", 2'b0, {rd[0], irq})
        step(4'h1, 4'h0, 16'h0200, 1'b0);
        step(4'h1, 4'h1, 16'h0100, 1'b0);
        step(4'h1, 4'h0, 16'h0110, 1'b0);
        step(4'h1, 4'h0, 16'h0120, 1'b1);
        apb(1'b1, `CIH_OFS_PEND, 32'h0);
        step(4'h1, 4'h1, 16'h0120, 1'b0);
        step(4'h1, 4'h0, 16'h0130, 1'b0);
        apb(1'b1, `CIH_OFS_HWCLR, 32'h10);
        apb(1'b1, `CIH_OFS_EN, 32'hb0);
        apb(1'b1, `CIH_OFS_PEND, 32'h10);
        step(4'h1, 4'h0, 16'h0300, 1'b1);
        `CHK("sw vector", vaddr(4), vec_addr)
        apb(1'b0, `CIH_OFS_PEND, 32'h0);
        `CHK("autoclr", 1'b0, rd[4])
        apb(1'b1, `CIH_OFS_PRIO, 32'h20);
        u_core.fire(8'h20);
        step(4'h1, 4'h0, 16'h0400, 1'b1);
        `CHK("preempt", vaddr(5), vec_addr)
        apb(1'b1, `CIH_OFS_IRQMSK, 32'h0);
        apb(1'b0, `CIH_OFS_IRQST, 32'h0);
        `CHK("irq mask", 2'b10, {rd[0], irq})
        complete_run();
    end
endmodule // tb_top
